// *** rtl/flash_status_pkg.sv ***
/*
  Constants, register map and shared types for the status-one flag block.
  Assumes a 10 MHz pclk and APB access with one aligned 32-bit word per register.
*/
package flash_status_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8; // Decoded address width
  localparam logic [7:0] STATUS_OFF = 8'h00; // Volatile status one, read only
  localparam logic [7:0] CMD_OFF = 8'h04; // Command code, write only
  localparam logic [7:0] PROT_OFF = 8'h08; // Protection control bits
  localparam logic [7:0] STATE_OFF = 8'h0C; // Validity and power state

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0; // Ready/busy flag
  localparam int WEL_BIT = 1; // Write enable flag
  localparam int ERS_ERR_BIT = 5; // Erase error flag
  localparam int PRG_ERR_BIT = 6; // Program error flag
  localparam int PROT_B1_BIT = 1; // Protection register bit 1
  localparam int PROT_B2_BIT = 2; // Protection register bit 2
  localparam int PWD_MODE_BIT = 3; // Password protection mode selected
  localparam int VALID_BIT = 0; // Status contents valid
  localparam int DPD_BIT = 1; // Deep power down active

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00; // All flags clear
  localparam logic [3:0] PROT_RESET = 4'h6; // Both protection bits at one

  // ----------------------------------------------------------------
  // Command codes written to CMD_OFF
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_WEL = 8'h01; // set_write_latch_cmd
  localparam logic [7:0] CMD_CLR_WEL = 8'h02; // clear_write_latch_cmd
  localparam logic [7:0] CMD_CLR_FAIL = 8'h03; // clear_failure_flags_cmd
  localparam logic [7:0] CMD_PROGRAM = 8'h04; // Start array program
  localparam logic [7:0] CMD_ERASE = 8'h05; // Start sector or device erase
  localparam logic [7:0] CMD_REG_WRITE = 8'h06; // Start non-volatile register write
  localparam logic [7:0] CMD_SOFT_RESET = 8'h07; // Software reset
  localparam logic [7:0] CMD_DPD_ENTER = 8'h08; // Enter deep power down
  localparam logic [7:0] CMD_DPD_EXIT = 8'h09; // Leave deep power down

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100; // pclk period
  localparam int RESET_TIME_NS = 1000; // Reset recovery window, least time
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8; // Width of the recovery counter

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_REGW} op_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_ERROR, ST_RESET} ctrl_state_t;

endpackage

// *** rtl/pin_sync.sv ***
/*
  Three-flop synchroniser for an asynchronous pin.
  Assumes the pin is slow against pclk; output moves once stages two and three agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and clean level
  input wire logic pin,
  output logic level
);

  // Synchroniser stages; stage one feeds stage two only
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      level <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Agreement filters a single metastable sample
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end

endmodule

// *** rtl/error_judge.sv ***
/*
  Classifies the result of an embedded operation into program and erase failures.
  Assumes condition inputs are valid in the cycle the operation reports completion.
*/
`timescale 1ns/1ps
module error_judge (
  // Operation identity
  input flash_status_pkg::op_kind_t kind,
  // Array engine conditions
  input wire logic bits_stuck,
  input wire logic region_protected,
  input wire logic erase_incomplete,
  input wire logic reg_erase_incomplete,
  input wire logic cfg_change_attempt,
  input wire logic password_write,
  // Protection settings
  input wire logic [1:0] prot_bits,
  input wire logic password_mode,
  // Verdict
  output logic prog_fail,
  output logic erase_fail
);
  import flash_status_pkg::*;

  // ----------------------------------------------------------------
  // Verdict logic
  // ----------------------------------------------------------------
  always_comb begin
    prog_fail = 1'b0;
    erase_fail = 1'b0;
    case (kind)
      OP_PROG: begin
        prog_fail = bits_stuck | region_protected;
      end
      OP_ERASE: begin
        erase_fail = erase_incomplete | region_protected;
      end
      OP_REGW: begin
        // Locked configuration field or password update after mode select
        prog_fail = (cfg_change_attempt & ~(&prot_bits))
                  | (password_mode & password_write);
        erase_fail = reg_erase_incomplete;
      end
      default: begin
        prog_fail = 1'b0;
      end
    endcase
  end

endmodule

// *** rtl/flash_status_one.sv ***
/*
  Status-one flag block: write enable latch, ready/busy, program and erase errors.
  Assumes an APB master on pclk and an array engine on the same clock that
  pulses op_done with its condition inputs valid in that cycle.
*/
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flash_status_one (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flash_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset pins, asynchronous
  input wire logic hw_reset_pin_n,
  input wire logic cs_reset_pin,
  // Array engine handshake
  output logic op_start,
  output flash_status_pkg::op_kind_t op_kind,
  input wire logic op_done,
  input wire logic bits_stuck,
  input wire logic region_protected,
  input wire logic erase_incomplete,
  input wire logic reg_erase_incomplete,
  input wire logic cfg_change_attempt,
  input wire logic password_write,
  input wire logic boot_check_fail,
  input wire logic config_load_fail,
  // Status out
  output logic [7:0] status_one,
  output logic status_valid
);
  import flash_status_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_state_t state_r; // Control state
  logic wel_r; // write_enable_flag
  logic prg_err_r; // program_error_flag
  logic ers_err_r; // erase_error_flag
  logic dpd_r; // deep_power_down active
  logic [3:0] prot_r; // Protection bits and password mode
  logic [RST_CNT_W-1:0] rst_cnt_r; // Reset recovery countdown
  logic hw_rst_n; // Synchronised hardware reset pin
  logic cs_rst; // Synchronised chip-select signalling reset
  logic prog_fail; // Verdict from judge
  logic erase_fail; // Verdict from judge
  logic wr_fire; // Write completes this edge
  logic rd_load; // Read data captured this edge
  logic [7:0] cmd; // Command byte
  logic cmd_ok; // Command write completes
  logic any_reset; // Any non-power reset event
  logic modify_cmd; // Program, erase or register write command
  logic op_accept; // Modify command is admitted
  logic boot_fail; // Boot-time integrity or load failure
  logic [7:0] status_nxt; // Composed status byte
  logic [7:0] reset_cycles_w; // Recovery length at counter width

  assign reset_cycles_w = RST_CNT_W'(RESET_CYCLES);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Known register address check
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == STATUS_OFF) || (a == CMD_OFF) || (a == PROT_OFF) || (a == STATE_OFF);
  endfunction

  // Command maps to one of the three modifying operations
  function automatic logic is_modify(input logic [7:0] c);
    is_modify = (c == CMD_PROGRAM) || (c == CMD_ERASE) || (c == CMD_REG_WRITE);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.INIT(1'b1)) u_hw_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(hw_reset_pin_n),
    .level(hw_rst_n)
  );

  pin_sync #(.INIT(1'b0)) u_cs_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(cs_reset_pin),
    .level(cs_rst)
  );

  // ----------------------------------------------------------------
  // Failure classification
  // ----------------------------------------------------------------
  error_judge u_judge (
    .kind(op_kind),
    .bits_stuck(bits_stuck),
    .region_protected(region_protected),
    .erase_incomplete(erase_incomplete),
    .reg_erase_incomplete(reg_erase_incomplete),
    .cfg_change_attempt(cfg_change_attempt),
    .password_write(password_write),
    .prot_bits({prot_r[PROT_B2_BIT], prot_r[PROT_B1_BIT]}),
    .password_mode(prot_r[PWD_MODE_BIT]),
    .prog_fail(prog_fail),
    .erase_fail(erase_fail)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // One wait state: pready rises one cycle into the access phase
  assign wr_fire = psel & penable & pwrite & pready;
  assign rd_load = psel & penable & ~pready;
  assign cmd = pwdata[7:0];
  assign cmd_ok = wr_fire && (paddr == CMD_OFF);
  assign modify_cmd = cmd_ok && is_modify(cmd);
  // Power-down blocks operations and soft reset; its own exit and the reset pins still act
  assign op_accept = modify_cmd && (state_r == ST_IDLE) && wel_r && !dpd_r;
  assign any_reset = !hw_rst_n || cs_rst
                   || (cmd_ok && !dpd_r && (cmd == CMD_SOFT_RESET))
                   || (cmd_ok && dpd_r && (cmd == CMD_DPD_EXIT));
  // Boot failures are only reported once reset recovery is over
  assign boot_fail = (boot_check_fail || config_load_fail) && (state_r != ST_RESET);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RESET;
      rst_cnt_r <= RST_CNT_W'(RESET_CYCLES);
    end else if (any_reset) begin
      state_r <= ST_RESET;
      rst_cnt_r <= reset_cycles_w;
    end else begin
      case (state_r)
        ST_RESET: begin
          // Recovery window, status not valid
          if (rst_cnt_r <= 8'h01) begin
            state_r <= ST_IDLE;
            rst_cnt_r <= 8'h00;
          end else begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
          end
        end
        ST_IDLE: begin
          if (boot_fail) begin
            state_r <= ST_ERROR;
          end else if (op_accept) begin
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Boot failure wins, so the flags it sets never meet a standby state
          if (boot_fail) begin
            state_r <= ST_ERROR;
          end else if (op_done) begin
            state_r <= (prog_fail || erase_fail) ? ST_ERROR : ST_IDLE;
          end
        end
        ST_ERROR: begin
          // A fresh failure in the clearing cycle keeps the part held
          if (cmd_ok && (cmd == CMD_CLR_FAIL) && !boot_fail) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_r <= 1'b0;
    end else if (any_reset || state_r == ST_RESET) begin
      wel_r <= 1'b0;
    end else if (state_r == ST_BUSY && op_done && !prog_fail && !erase_fail) begin
      wel_r <= 1'b0;
    end else if (cmd_ok && state_r == ST_IDLE && !dpd_r) begin
      // Latch commands are ignored while busy or held in error
      if (cmd == CMD_SET_WEL) begin
        wel_r <= 1'b1;
      end else if (cmd == CMD_CLR_WEL) begin
        wel_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Set wins over the clear-failure command in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prg_err_r <= 1'b0;
      ers_err_r <= 1'b0;
    end else if (any_reset || state_r == ST_RESET) begin
      prg_err_r <= 1'b0;
      ers_err_r <= 1'b0;
    end else begin
      if (boot_fail) begin
        prg_err_r <= 1'b1;
        ers_err_r <= 1'b1;
      end else if (state_r == ST_BUSY && op_done) begin
        // Results land only while the busy bit is up
        prg_err_r <= prog_fail;
        ers_err_r <= erase_fail;
      end else if (state_r == ST_ERROR && cmd_ok && cmd == CMD_CLR_FAIL) begin
        prg_err_r <= 1'b0;
        ers_err_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Deep power down and protection bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpd_r <= 1'b0;
    end else if (cmd_ok && state_r == ST_IDLE && cmd == CMD_DPD_ENTER) begin
      dpd_r <= 1'b1;
    end else if (any_reset) begin
      dpd_r <= 1'b0;
    end
  end

  // Protection bits are plain storage; the judge reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= PROT_RESET;
    end else if (wr_fire && paddr == PROT_OFF) begin
      prot_r <= {pwdata[PWD_MODE_BIT], pwdata[PROT_B2_BIT], pwdata[PROT_B1_BIT], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Operation launch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start <= 1'b0;
      op_kind <= OP_PROG;
    end else begin
      op_start <= op_accept;
      if (op_accept) begin
        op_kind <= (cmd == CMD_PROGRAM) ? OP_PROG : (cmd == CMD_ERASE) ? OP_ERASE : OP_REGW;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status composition
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = STATUS_RESET;
    status_nxt[BUSY_BIT] = (state_r != ST_IDLE);
    status_nxt[WEL_BIT] = wel_r;
    status_nxt[ERS_ERR_BIT] = ers_err_r;
    status_nxt[PRG_ERR_BIT] = prg_err_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_one <= STATUS_RESET;
      status_valid <= 1'b0;
    end else begin
      status_one <= status_nxt;
      status_valid <= (state_r != ST_RESET) && !any_reset;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_load;
      pslverr <= rd_load && !addr_mapped(paddr);
      if (rd_load && !pwrite) begin
        case (paddr)
          STATUS_OFF: prdata <= {24'h00_0000, status_nxt};
          PROT_OFF: prdata <= {28'h000_0000, prot_r};
          STATE_OFF: prdata <= {30'h0, dpd_r, state_r != ST_RESET};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_no_start_locked: assert property (op_start |-> $past(wel_r))
    else $error("operation started without write enable");
  a_set_latch: assert property (cmd_ok && cmd == CMD_SET_WEL && state_r == ST_IDLE
    && !dpd_r && !any_reset |=> wel_r)
    else $error("set latch command ignored");
  a_clear_latch: assert property (cmd_ok && cmd == CMD_CLR_WEL && state_r == ST_IDLE && !dpd_r
    |=> !wel_r)
    else $error("clear latch command ignored");
  a_done_clears: assert property (state_r == ST_BUSY && op_done && !prog_fail
    && !erase_fail |=> !wel_r ##1 !status_one[WEL_BIT])
    else $error("latch kept after good operation");
  a_reset_clears: assert property (any_reset |=> !wel_r && state_r == ST_RESET)
    else $error("reset left latch set");
  a_busy_bit: assert property (op_start |=> status_one[BUSY_BIT])
    else $error("busy not shown during operation");
  a_err_only_busy: assert property ($rose(prg_err_r) && !$past(boot_fail)
    |-> $past(state_r) == ST_BUSY)
    else $error("error flag set outside busy");
  a_err_holds: assert property ((prg_err_r || ers_err_r) |-> state_r != ST_IDLE
    && !op_accept)
    else $error("error flag without busy hold");
  a_clear_fail: assert property (state_r == ST_ERROR && cmd_ok && cmd == CMD_CLR_FAIL
    && !boot_fail && !any_reset |=> !prg_err_r && !ers_err_r ##1 !status_one[BUSY_BIT])
    else $error("clear failure did not return to standby");
  a_invalid_reset: assert property (any_reset |=> !status_valid [*8])
    else $error("status valid during reset");
  a_prog_fault: assert property (state_r == ST_BUSY && op_done && op_kind == OP_PROG
    && region_protected && !any_reset |=> prg_err_r)
    else $error("protected program not flagged");

  c_good_op: cover property (op_start ##[1:50] (state_r == ST_IDLE && !wel_r));
  c_error_clear: cover property (state_r == ST_ERROR ##[1:50] state_r == ST_IDLE);
  c_soft_reset: cover property (any_reset ##[1:20] status_valid);

endmodule

// *** tb/op_engine_model.sv ***
/*
  Array engine stand-in: answers op_start with op_done after dly cycles.
  Assumes pclk is shared with the block; fault selects the done conditions.
*/
`timescale 1ns/1ps
module op_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Start from block, settings from bench
  input wire logic op_start,
  input wire logic [3:0] dly,
  input wire logic [5:0] fault,
  // Completion and conditions
  output logic op_done,
  output logic [5:0] cond
);
  logic [3:0] cnt_r; // Cycles left in the running operation
  // ----------
  // Countdown
  // ----------
  // Conditions toggle off the done cycle so stale values are never trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      op_done <= 1'b0;
      cond <= 6'h00;
    end else begin
      op_done <= 1'b0;
      cond <= ~cond;
      if (op_start) begin
        cnt_r <= dly;
      end else if (cnt_r > 4'h1) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (cnt_r == 4'h1) begin
        cnt_r <= 4'h0;
        op_done <= 1'b1;
        cond <= fault;
      end
    end
  end
endmodule

// *** tb/flash_status_one_flags_tb.sv ***
/*
  Self-checking bench for the status-one flag block over APB.
  Assumes the design package and the engine model on the same pclk.
*/
`timescale 1ns/1ps
module flash_status_one_flags_tb;
  import flash_status_pkg::*;
  // ----------
  // Signals
  // ----------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hw_n = 1'b1; // Hardware reset pin, active low
  logic cs_rst = 1'b0; // Chip-select signalling reset
  logic [1:0] boot_f = 2'h0; // Boot check, config load failures
  logic op_start;
  logic op_done;
  logic [3:0] dly = 4'h6; // Engine latency, random per op
  logic [5:0] fault = 6'h00;
  logic [5:0] cond;
  logic [32:0] exq [$]; // Expected {pslverr, prdata}
  logic [32:0] mon_e; // Note taken off the read queue
  logic [7:0] st1; // Status byte port
  logic st_valid; // Status valid port
  logic [1:0] kind_w; // Operation kind port
  logic [1:0] kq [$]; // Expected kind of each launched operation
  int fails = 0;
  int compares = 0;
  // Operation table: protection, command, conditions, status after done
  logic [3:0] t_prot [13] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
    4'h6, 4'h2, 4'h4, 4'h6, 4'hE, 4'h6};
  logic [7:0] t_cmd [13] = '{CMD_PROGRAM, CMD_ERASE, CMD_REG_WRITE,
    CMD_PROGRAM, CMD_PROGRAM, CMD_ERASE, CMD_ERASE, CMD_REG_WRITE,
    CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE};
  logic [5:0] t_flt [13] = '{6'h00, 6'h00, 6'h00, 6'h01, 6'h02, 6'h04,
    6'h02, 6'h08, 6'h10, 6'h10, 6'h10, 6'h20, 6'h20};
  logic [7:0] t_exp [13] = '{8'h00, 8'h00, 8'h00, 8'h43, 8'h43, 8'h23,
    8'h23, 8'h23, 8'h43, 8'h43, 8'h00, 8'h43, 8'h00};
  always #50 pclk = ~pclk;
  // ----------
  // Design and engine
  // ----------
  flash_status_one DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_reset_pin_n(hw_n), .cs_reset_pin(cs_rst), .op_start(op_start),
    .op_kind(kind_w), .op_done(op_done), .bits_stuck(cond[0]),
    .region_protected(cond[1]), .erase_incomplete(cond[2]),
    .reg_erase_incomplete(cond[3]), .cfg_change_attempt(cond[4]),
    .password_write(cond[5]), .boot_check_fail(boot_f[0]),
    .config_load_fail(boot_f[1]), .status_one(st1), .status_valid(st_valid));
  op_engine_model ENG (.pclk(pclk), .presetn(presetn), .op_start(op_start),
    .dly(dly), .fault(fault), .op_done(op_done), .cond(cond));
  // ----------
  // Tasks
  // ----------
  // APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // Upper bits are random noise the block must ignore
    xfer(1'b1, a, {24'($urandom), d});
  endtask
  // Bounded wait on the engine's completion, then let flags land
  task automatic done_wait();
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      conclude();
    end
    repeat (2) @(posedge pclk);
  endtask
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch prdata expected %h seen %h", e, g);
    end
  endtask
  // Port values, named in the report
  task automatic cmp_port(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read monitor: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0) begin
      mon_e = exq.pop_front();
      cmp(mon_e, {pslverr, prdata});
      // Port copies were loaded at the same edge as the read data
      if (paddr == STATUS_OFF) begin
        cmp_port("status_one", {25'h0, mon_e[7:0]}, {25'h0, st1});
      end
      if (paddr == STATE_OFF) begin
        cmp_port("status_valid", {32'h0, mon_e[0]}, {32'h0, st_valid});
      end
    end
  end
  // Start monitor: every launch against its note, none without one
  always @(posedge pclk) begin
    if (op_start === 1'b1) begin
      if (kq.size() == 0) begin
        cmp_port("op_start", 33'h0, 33'h1);
      end else begin
        cmp_port("op_kind", {31'h0, kq.pop_front()}, {31'h0, kind_w});
      end
    end
  end
  // Watchdog, well beyond the expected run
  initial begin
    #(20000 * CLK_PERIOD_NS);
    fails++;
    conclude();
  end
  // ----------
  // Tests
  // ----------
  initial begin
    int i;
    int k;
    void'($urandom(39));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(STATE_OFF, 33'h0);
    rd(STATUS_OFF, 33'h1);
    repeat (RESET_CYCLES + 2) @(posedge pclk);
    rd(STATE_OFF, 33'h1);
    rd(STATUS_OFF, 33'h0);
    $display("test reset done");
    wr(CMD_OFF, CMD_PROGRAM);
    rd(STATUS_OFF, 33'h0);
    wr(CMD_OFF, CMD_SET_WEL);
    rd(STATUS_OFF, 33'h2);
    wr(CMD_OFF, CMD_CLR_WEL);
    wr(CMD_OFF, CMD_ERASE);
    rd(STATUS_OFF, 33'h0);
    $display("test latch done");
    for (i = 0; i < 13; i++) begin
      dly <= 4'(6 + $urandom % 6);
      fault <= t_flt[i];
      wr(PROT_OFF, {4'h0, t_prot[i]});
      wr(CMD_OFF, CMD_SET_WEL);
      kq.push_back((t_cmd[i] == CMD_PROGRAM) ? OP_PROG
        : (t_cmd[i] == CMD_ERASE) ? OP_ERASE : OP_REGW);
      wr(CMD_OFF, t_cmd[i]);
      rd(STATUS_OFF, 33'h3);
      done_wait();
      rd(STATUS_OFF, {25'h0, t_exp[i]});
      if (t_exp[i][0]) begin
        wr(CMD_OFF, CMD_PROGRAM);
        rd(STATUS_OFF, {25'h0, t_exp[i]});
        wr(CMD_OFF, CMD_CLR_FAIL);
        rd(STATUS_OFF, 33'h2);
        wr(CMD_OFF, CMD_CLR_WEL);
      end
    end
    $display("test operations done");
    for (k = 0; k < 2; k++) begin
      boot_f[k] <= 1'b1;
      @(posedge pclk);
      boot_f <= 2'h0;
      repeat (2) @(posedge pclk);
      rd(STATUS_OFF, 33'h61);
      wr(CMD_OFF, CMD_CLR_FAIL);
      rd(STATUS_OFF, 33'h0);
    end
    $display("test boot failure done");
    for (k = 0; k < 4; k++) begin
      wr(CMD_OFF, CMD_SET_WEL);
      case (k)
        0: wr(CMD_OFF, CMD_SOFT_RESET);
        1: begin
          wr(CMD_OFF, CMD_DPD_ENTER);
          wr(CMD_OFF, CMD_DPD_EXIT);
        end
        2: begin
          hw_n <= 1'b0;
          repeat (6) @(posedge pclk);
          hw_n <= 1'b1;
        end
        default: begin
          cs_rst <= 1'b1;
          repeat (6) @(posedge pclk);
          cs_rst <= 1'b0;
        end
      endcase
      rd(STATUS_OFF, 33'h1);
      repeat (RESET_CYCLES + 6) @(posedge pclk);
      rd(STATUS_OFF, 33'h0);
    end
    $display("test resets done");
    rd(8'h10, 33'h100000000);
    $display("test unmapped done");
    conclude();
  end
endmodule
